// File: design/ale_exec.sv
// Executer for the arithmetic and logic instruction group of the 8-bit core
// Operation
// - Standard opcode encodings and behaviour so existing binaries run unchanged.
// - Indirect operand is the internal byte pointed to by working register 0 or 1.
// - Branch displacement byte is signed two's complement, added to the program counter.
// - Sum into accumulator: 1 byte register/indirect, 2 bytes direct/immediate, 1 cycle.
// - Sum with carry adds source and carry flag; same lengths, 1 cycle.
// - Subtract with borrow removes source and carry; same lengths, 1 cycle.
// - AND and OR into accumulator: 1 or 2 bytes, 1 cycle.
// - AND, OR, XOR of accumulator into direct byte: 2 bytes, 1 cycle.
// - AND, OR, XOR of immediate into direct byte: 3 bytes, 2 cycles.
// - XOR into accumulator: 1 or 2 bytes, 1 cycle.
// - Rotate left through carry: carry to bit 0, bit 7 to carry, 1 byte, 1 cycle.
// - Rotate right through carry: carry to bit 7, bit 0 to carry, 1 byte, 1 cycle.
`timescale 1ns/10ps
`include "ale_defines.svh"

module ale_exec #(
  parameter int MC_CLKS = `ALE_MC_CLKS
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic             instr_valid,
  input  wire logic [7:0]       opcode,
  input  wire logic [7:0]       operand1,
  input  wire logic [7:0]       operand2,
  input  wire logic [15:0]      pc_value,
  input  wire logic [1:0]       reg_bank,
  input  wire logic [7:0]       mem_rdata,
  output logic                  busy,
  output logic                  done,
  output logic                  illegal,
  output logic [1:0]            instr_len,
  output logic [1:0]            instr_cycles,
  output logic [15:0]           branch_target,
  output logic [7:0]            acc,
  output ale_pkg::ale_flags_t   flags,
  output logic [7:0]            mem_addr,
  output logic                  mem_rd,
  output logic                  mem_wr,
  output logic [7:0]            mem_wdata
);

  localparam int CNT_W = 8;

  ale_pkg::ale_state_t  state_reg;
  ale_pkg::ale_dec_t    dec_now;
  ale_pkg::ale_dec_t    dec_reg;
  ale_pkg::ale_alu_t    alu_out;
  logic [7:0]           op1_reg;
  logic [7:0]           op2_reg;
  logic [7:0]           opnd;
  logic [7:0]           alu_x;
  logic [7:0]           alu_y;
  logic [CNT_W-1:0]     cnt_reg;
  logic [CNT_W-1:0]     cnt_next;
  logic                 accept;
  logic                 ptr_hold_reg;

  // Signed displacement, sign extended to the program counter width
  function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [7:0] disp);
    rel_target = pc + {{8{disp[7]}}, disp};
  endfunction

  // Address of working register n in the selected bank
  function automatic logic [7:0] work_reg(input logic [1:0] bank, input logic [2:0] n);
    work_reg = {3'h0, bank, n};
  endfunction

  ale_decoder u_dec (
    .opcode (opcode),
    .dec    (dec_now)
  );

  // Read data stands on the port from the edge after the read until the next read,
  // so EXEC takes it straight from there instead of a stale copy
  assign opnd = (dec_reg.src == ale_pkg::ALE_SRC_IMM) ? op1_reg : mem_rdata;

  // Direct destination: fetched byte is the left operand
  assign alu_x = dec_reg.dst_dir ? opnd : acc;
  assign alu_y = dec_reg.dst_dir ? (dec_reg.imm_to_dir ? op2_reg : acc) : opnd;

  ale_alu u_alu (
    .op    (dec_reg.op),
    .x     (alu_x),
    .y     (alu_y),
    .cy_in (flags.cy),
    .out   (alu_out)
  );

  // Unsupported opcodes are flagged and dropped without touching acc, flags or memory
  assign accept = (state_reg == ale_pkg::ALE_ST_IDLE) && instr_valid;

  // Total duration counted from acceptance: instruction cycles times clocks per cycle
  assign cnt_next = CNT_W'(dec_now.cycles * MC_CLKS - 1);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg <= ale_pkg::ALE_ST_IDLE;
    end else begin
      unique case (state_reg)
        ale_pkg::ALE_ST_IDLE: begin
          if (accept && dec_now.legal) begin
            unique case (dec_now.src)
              ale_pkg::ALE_SRC_IND: state_reg <= ale_pkg::ALE_ST_PTR;
              ale_pkg::ALE_SRC_REG, ale_pkg::ALE_SRC_DIR: state_reg <= ale_pkg::ALE_ST_FETCH;
              default: state_reg <= ale_pkg::ALE_ST_EXEC;
            endcase
          end
        end
        ale_pkg::ALE_ST_PTR: begin
          if (ptr_hold_reg) begin
            state_reg <= ale_pkg::ALE_ST_FETCH;
          end
        end
        ale_pkg::ALE_ST_FETCH: state_reg <= ale_pkg::ALE_ST_EXEC;
        ale_pkg::ALE_ST_EXEC:  state_reg <= ale_pkg::ALE_ST_WAIT;
        ale_pkg::ALE_ST_WAIT: begin
          if (cnt_reg == '0) begin
            state_reg <= ale_pkg::ALE_ST_IDLE;
          end
        end
        default: state_reg <= ale_pkg::ALE_ST_IDLE;
      endcase
    end
  end

  // Latch the instruction and its trailing bytes on acceptance
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dec_reg <= '0;
      op1_reg <= 8'h00;
      op2_reg <= 8'h00;
      instr_len <= 2'h0;
      instr_cycles <= 2'h0;
      branch_target <= 16'h0000;
    end else if (accept) begin
      dec_reg <= dec_now;
      op1_reg <= operand1;
      op2_reg <= operand2;
      instr_len <= dec_now.len;
      instr_cycles <= dec_now.cycles;
      branch_target <= rel_target(pc_value, operand1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_reg <= '0;
    end else if (accept) begin
      cnt_reg <= cnt_next;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - CNT_W'(1);
    end
  end

  // Data memory port: reads return one clock after the request
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mem_addr <= 8'h00;
      mem_rd <= 1'b0;
    end else begin
      mem_rd <= 1'b0;
      if (accept && dec_now.legal) begin
        unique case (dec_now.src)
          ale_pkg::ALE_SRC_REG: begin
            mem_addr <= work_reg(reg_bank, opcode[2:0]);
            mem_rd <= 1'b1;
          end
          ale_pkg::ALE_SRC_IND: begin
            mem_addr <= work_reg(reg_bank, {2'h0, opcode[`ALE_PTR_SEL_BIT]});
            mem_rd <= 1'b1;
          end
          ale_pkg::ALE_SRC_DIR: begin
            mem_addr <= operand1;
            mem_rd <= 1'b1;
          end
          default: mem_rd <= 1'b0;
        endcase
      end else if (state_reg == ale_pkg::ALE_ST_PTR && ptr_hold_reg) begin
        // Pointer value names the internal location, never external space
        mem_addr <= mem_rdata;
        mem_rd <= 1'b1;
      end
    end
  end

  // Pointer byte arrives one clock after its read, so PTR lasts two clocks
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ptr_hold_reg <= 1'b0;
    end else begin
      ptr_hold_reg <= (state_reg == ale_pkg::ALE_ST_PTR) && !ptr_hold_reg;
    end
  end

  // Write back to a direct byte; mem_addr still holds the direct address
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mem_wr <= 1'b0;
      mem_wdata <= 8'h00;
    end else begin
      mem_wr <= (state_reg == ale_pkg::ALE_ST_EXEC) && dec_reg.dst_dir;
      if (state_reg == ale_pkg::ALE_ST_EXEC) begin
        mem_wdata <= alu_out.res;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      acc <= `ALE_ACC_RST;
    end else if (state_reg == ale_pkg::ALE_ST_EXEC && !dec_reg.dst_dir) begin
      acc <= alu_out.res;
    end
  end

  // Logic ops leave the flags alone; rotates touch only carry
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      flags <= {`ALE_FLAG_RST, `ALE_FLAG_RST, `ALE_FLAG_RST};
    end else if (state_reg == ale_pkg::ALE_ST_EXEC) begin
      unique case (dec_reg.op)
        ale_pkg::ALE_OP_SUM, ale_pkg::ALE_OP_SUMC, ale_pkg::ALE_OP_SUBTRACT_WITH_BORROW: begin
          flags.cy <= alu_out.cy;
          flags.ac <= alu_out.ac;
          flags.ov <= alu_out.ov;
        end
        ale_pkg::ALE_OP_ROTL, ale_pkg::ALE_OP_ROTR: flags.cy <= alu_out.cy;
        default: flags <= flags;
      endcase
    end
  end

  // Done marks the end of the instruction's full cycle budget, never before write-back
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      illegal <= 1'b0;
    end else begin
      done <= (state_reg == ale_pkg::ALE_ST_WAIT) && (cnt_reg == '0);
      illegal <= accept && !dec_now.legal;
      if (accept && dec_now.legal) begin
        busy <= 1'b1;
      end else if (state_reg == ale_pkg::ALE_ST_WAIT && cnt_reg == '0) begin
        busy <= 1'b0;
      end
    end
  end

endmodule

// File: design/ale_defines.svh
// Opcode fields, encodings, lengths, cycle counts and reset values of the executer
`ifndef ALE_DEFINES_SVH
`define ALE_DEFINES_SVH

// Opcode high nibble: operation class
`define ALE_HI_SUM      4'h2
`define ALE_HI_SUMC     4'h3
`define ALE_HI_SUBTRACT_WITH_BORROW     4'h9
`define ALE_HI_OR       4'h4
`define ALE_HI_AND      4'h5
`define ALE_HI_XOR      4'h6

// Opcode low nibble: operand addressing
`define ALE_LO_DIR_ACC  4'h2
`define ALE_LO_DIR_IMM  4'h3
`define ALE_LO_IMM      4'h4
`define ALE_LO_DIR      4'h5
`define ALE_LO_IND_LO   4'h6
`define ALE_LO_IND_HI   4'h7

// Whole opcodes of the rotates through carry
`define ALE_OPC_ROT_L   8'h33
`define ALE_OPC_ROT_R   8'h13

// Field positions inside the opcode
`define ALE_REG_SEL_BIT 3
`define ALE_PTR_SEL_BIT 0

// Instruction lengths in bytes and durations in instruction cycles
`define ALE_LEN_ONE     2'h1
`define ALE_LEN_TWO     2'h2
`define ALE_LEN_THREE   2'h3
`define ALE_CYC_ONE     2'h1
`define ALE_CYC_TWO     2'h2

// Core clocks per instruction cycle
`define ALE_MC_CLKS     12

// Reset values
`define ALE_ACC_RST     8'h00
`define ALE_FLAG_RST    1'b0

`endif

// File: design/ale_pkg.sv
// Types shared by the arithmetic and logic executer
package ale_pkg;

  typedef enum logic [3:0] {
    ALE_OP_NONE  = 4'h0,
    ALE_OP_SUM   = 4'h1,
    ALE_OP_SUMC  = 4'h2,
    ALE_OP_SUBTRACT_WITH_BORROW  = 4'h3,
    ALE_OP_AND   = 4'h4,
    ALE_OP_OR    = 4'h5,
    ALE_OP_XOR   = 4'h6,
    ALE_OP_ROTL  = 4'h7,
    ALE_OP_ROTR  = 4'h8
  } ale_op_t;

  typedef enum logic [2:0] {
    ALE_SRC_NONE = 3'h0,
    ALE_SRC_REG  = 3'h1,
    ALE_SRC_IND  = 3'h2,
    ALE_SRC_DIR  = 3'h3,
    ALE_SRC_IMM  = 3'h4
  } ale_src_t;

  typedef struct packed {
    logic        legal;
    ale_op_t     op;
    ale_src_t    src;
    logic        dst_dir;
    logic        imm_to_dir;
    logic [1:0]  len;
    logic [1:0]  cycles;
  } ale_dec_t;

  typedef struct packed {
    logic [7:0]  res;
    logic        cy;
    logic        ac;
    logic        ov;
  } ale_alu_t;

  typedef struct packed {
    logic        cy;
    logic        ac;
    logic        ov;
  } ale_flags_t;

  typedef enum logic [4:0] {
    ALE_ST_IDLE  = 5'b00001,
    ALE_ST_PTR   = 5'b00010,
    ALE_ST_FETCH = 5'b00100,
    ALE_ST_EXEC  = 5'b01000,
    ALE_ST_WAIT  = 5'b10000
  } ale_state_t;

endpackage

// File: design/ale_decoder.sv
// Opcode decoder for the arithmetic and logic instruction group
`timescale 1ns/10ps
`include "ale_defines.svh"

module ale_decoder (
  input  wire logic [7:0]       opcode,
  output ale_pkg::ale_dec_t     dec
);

  logic [3:0] hi;
  logic [3:0] lo;

  assign hi = opcode[7:4];
  assign lo = opcode[3:0];

  always_comb begin
    dec = '0;
    dec.op = ale_pkg::ALE_OP_NONE;
    dec.src = ale_pkg::ALE_SRC_NONE;
    unique case (hi)
      `ALE_HI_SUM:  dec.op = ale_pkg::ALE_OP_SUM;
      `ALE_HI_SUMC: dec.op = ale_pkg::ALE_OP_SUMC;
      `ALE_HI_SUBTRACT_WITH_BORROW: dec.op = ale_pkg::ALE_OP_SUBTRACT_WITH_BORROW;
      `ALE_HI_OR:   dec.op = ale_pkg::ALE_OP_OR;
      `ALE_HI_AND:  dec.op = ale_pkg::ALE_OP_AND;
      `ALE_HI_XOR:  dec.op = ale_pkg::ALE_OP_XOR;
      default:      dec.op = ale_pkg::ALE_OP_NONE;
    endcase
    dec.cycles = `ALE_CYC_ONE;
    if (opcode[`ALE_REG_SEL_BIT]) begin
      dec.src = ale_pkg::ALE_SRC_REG;
      dec.len = `ALE_LEN_ONE;
    end else begin
      unique case (lo)
        `ALE_LO_IND_LO, `ALE_LO_IND_HI: begin
          dec.src = ale_pkg::ALE_SRC_IND;
          dec.len = `ALE_LEN_ONE;
        end
        `ALE_LO_DIR: begin
          dec.src = ale_pkg::ALE_SRC_DIR;
          dec.len = `ALE_LEN_TWO;
        end
        `ALE_LO_IMM: begin
          dec.src = ale_pkg::ALE_SRC_IMM;
          dec.len = `ALE_LEN_TWO;
        end
        `ALE_LO_DIR_ACC: begin
          dec.src = ale_pkg::ALE_SRC_DIR;
          dec.dst_dir = 1'b1;
          dec.len = `ALE_LEN_TWO;
        end
        `ALE_LO_DIR_IMM: begin
          dec.src = ale_pkg::ALE_SRC_DIR;
          dec.dst_dir = 1'b1;
          dec.imm_to_dir = 1'b1;
          dec.len = `ALE_LEN_THREE;
          dec.cycles = `ALE_CYC_TWO;
        end
        default: dec.src = ale_pkg::ALE_SRC_NONE;
      endcase
    end
    // Only the logical ops have the forms that write a direct byte
    if (dec.dst_dir && (dec.op == ale_pkg::ALE_OP_SUM || dec.op == ale_pkg::ALE_OP_SUMC
        || dec.op == ale_pkg::ALE_OP_SUBTRACT_WITH_BORROW)) begin
      dec.op = ale_pkg::ALE_OP_NONE;
    end
    if (opcode == `ALE_OPC_ROT_L || opcode == `ALE_OPC_ROT_R) begin
      dec.op = (opcode == `ALE_OPC_ROT_L) ? ale_pkg::ALE_OP_ROTL : ale_pkg::ALE_OP_ROTR;
      dec.src = ale_pkg::ALE_SRC_NONE;
      dec.dst_dir = 1'b0;
      dec.imm_to_dir = 1'b0;
      dec.len = `ALE_LEN_ONE;
      dec.cycles = `ALE_CYC_ONE;
    end
    dec.legal = (dec.op != ale_pkg::ALE_OP_NONE) && (dec.src != ale_pkg::ALE_SRC_NONE
                || dec.op == ale_pkg::ALE_OP_ROTL || dec.op == ale_pkg::ALE_OP_ROTR);
    // Opcodes outside the group report no length
    if (!dec.legal) begin
      dec.len = 2'h0;
    end
  end

endmodule

// File: design/ale_alu.sv
// Combinational datapath: sums, subtract with borrow, logic ops, rotates through carry
`timescale 1ns/10ps

module ale_alu (
  input  ale_pkg::ale_op_t      op,
  input  wire logic [7:0]       x,
  input  wire logic [7:0]       y,
  input  wire logic             cy_in,
  output ale_pkg::ale_alu_t     out
);

  logic       cin;
  logic [4:0] nib;
  logic [7:0] low7;
  logic [8:0] full;

  // Plain sum ignores the carry; with-carry and borrow forms use it
  assign cin = (op == ale_pkg::ALE_OP_SUM) ? 1'b0 : cy_in;

  always_comb begin
    nib = 5'h00;
    low7 = 8'h00;
    full = 9'h000;
    out = '0;
    out.cy = cy_in;
    unique case (op)
      ale_pkg::ALE_OP_SUM, ale_pkg::ALE_OP_SUMC: begin
        nib = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
        low7 = {1'b0, x[6:0]} + {1'b0, y[6:0]} + {7'h00, cin};
        full = {1'b0, x} + {1'b0, y} + {8'h00, cin};
        out.res = full[7:0];
        out.cy = full[8];
        out.ac = nib[4];
        out.ov = full[8] ^ low7[7];
      end
      ale_pkg::ALE_OP_SUBTRACT_WITH_BORROW: begin
        // Borrow out of each position shows as the top bit of the wider difference
        nib = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, cin};
        low7 = {1'b0, x[6:0]} - {1'b0, y[6:0]} - {7'h00, cin};
        full = {1'b0, x} - {1'b0, y} - {8'h00, cin};
        out.res = full[7:0];
        out.cy = full[8];
        out.ac = nib[4];
        out.ov = full[8] ^ low7[7];
      end
      ale_pkg::ALE_OP_AND: out.res = x & y;
      ale_pkg::ALE_OP_OR:  out.res = x | y;
      ale_pkg::ALE_OP_XOR: out.res = x ^ y;
      ale_pkg::ALE_OP_ROTL: begin
        out.res = {x[6:0], cy_in};
        out.cy = x[7];
      end
      ale_pkg::ALE_OP_ROTR: begin
        out.res = {cy_in, x[7:1]};
        out.cy = x[0];
      end
      default: out.res = x;
    endcase
  end

endmodule

// File: sim/ale_exec_properties.sv
// Port-level checks for the arithmetic and logic executer
`timescale 1ns/10ps

module ale_exec_props #(
  parameter int MC_CLKS = 12
) (
  input wire logic           core_clk,
  input wire logic           sys_rst,
  input wire logic           instr_valid,
  input wire logic [7:0]     opcode,
  input wire logic [7:0]     operand1,
  input wire logic [15:0]    pc_value,
  input wire logic           busy,
  input wire logic           done,
  input wire logic           illegal,
  input wire logic [1:0]     instr_len,
  input wire logic [1:0]     instr_cycles,
  input wire logic [15:0]    branch_target,
  input wire logic [7:0]     acc,
  input ale_pkg::ale_flags_t flags,
  input wire logic [7:0]     mem_addr,
  input wire logic           mem_wr
);
  logic [7:0]  op_reg;
  logic [7:0]  arg_reg;
  logic [15:0] pc_reg;
  logic [7:0]  acc_cap_reg;
  logic        cy_cap_reg;
  logic [5:0]  cnt_reg;
  logic        take;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  function automatic logic grp(input logic [7:0] o);
    grp = o[7:4] inside {4'h4, 4'h5, 4'h6};
  endfunction

  function automatic logic lgl(input logic [7:0] o);
    lgl = o == 8'h33 || o == 8'h13 || (grp(o) && o[3:0] > 4'h1)
      || (o[7:4] inside {4'h2, 4'h3, 4'h9} && o[3:0] > 4'h3);
  endfunction

  assign take = instr_valid && !busy;

  // Snapshot of the accepted instruction, held while it runs
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      op_reg <= 8'h00;
      arg_reg <= 8'h00;
      pc_reg <= 16'h0000;
      acc_cap_reg <= 8'h00;
      cy_cap_reg <= 1'b0;
    end else if (take) begin
      op_reg <= opcode;
      arg_reg <= operand1;
      pc_reg <= pc_value;
      acc_cap_reg <= acc;
      cy_cap_reg <= flags.cy;
    end
  end

  // Saturates so a long stall never wraps into a false match
  always_ff @(posedge core_clk) begin
    if (sys_rst || take) begin
      cnt_reg <= 6'h01;
    end else if (cnt_reg != 6'h3f) begin
      cnt_reg <= cnt_reg + 6'h01;
    end
  end

  a_illegal_pulse: assert property (take && !lgl(opcode) |-> ##[1:2] illegal)
    else $error("unsupported opcode not flagged");
  a_illegal_idle: assert property (illegal |-> !busy && !done)
    else $error("unsupported opcode started work");
  a_legal_busy: assert property (take && lgl(opcode) |-> ##[1:2] busy)
    else $error("accepted opcode did not start");
  a_done_single: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_done_timing: assert property (done |-> cnt_reg >= instr_cycles * MC_CLKS
    && cnt_reg <= instr_cycles * MC_CLKS + 2)
    else $error("instruction duration wrong");
  a_len_cycles: assert property (done |-> instr_cycles ==
    ((grp(op_reg) && op_reg[3:0] == 4'h3) ? 2'h2 : 2'h1)
    && instr_len == ((grp(op_reg) && op_reg[3:0] == 4'h3) ? 2'h3
    : (op_reg[3:0] < 4'h6 && !(op_reg == 8'h33 || op_reg == 8'h13)) ? 2'h2 : 2'h1))
    else $error("length or cycle count wrong");
  a_target_calc: assert property (done |->
    branch_target == pc_reg + {{8{arg_reg[7]}}, arg_reg})
    else $error("branch target wrong");
  a_rotl_result: assert property (done && op_reg == 8'h33 |->
    acc == {acc_cap_reg[6:0], cy_cap_reg} && flags.cy == acc_cap_reg[7])
    else $error("left rotate wrong");
  a_rotr_result: assert property (done && op_reg == 8'h13 |->
    acc == {cy_cap_reg, acc_cap_reg[7:1]} && flags.cy == acc_cap_reg[0])
    else $error("right rotate wrong");
  a_logic_flags: assert property (busy && grp(op_reg) |-> $stable(flags))
    else $error("logic op changed flags");
  a_dir_keeps_acc: assert property (busy && grp(op_reg) && op_reg[3:0] < 4'h4
    |-> $stable(acc))
    else $error("direct destination changed acc");
  a_write_addr: assert property (mem_wr |-> mem_addr == arg_reg)
    else $error("write not to direct byte");

  c_rotate: cover property (take && opcode == 8'h33);
  c_two_cycle: cover property (done && instr_cycles == 2'h2);
  c_illegal: cover property (illegal);
  c_write: cover property (mem_wr);
endmodule

bind ale_exec ale_exec_props #(.MC_CLKS(MC_CLKS)) ale_exec_props_i (
  .core_clk(core_clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
  .opcode(opcode), .operand1(operand1), .pc_value(pc_value), .busy(busy),
  .done(done), .illegal(illegal), .instr_len(instr_len),
  .instr_cycles(instr_cycles), .branch_target(branch_target), .acc(acc),
  .flags(flags), .mem_addr(mem_addr), .mem_wr(mem_wr)
);

// File: sim/test_arith_logic_instr_exec.sv
// Self-checking bench for the arithmetic and logic executer
`timescale 1ns/10ps

`define CHK(nm, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
      fails++; \
      $display("mismatch %s exp %h got %h", nm, e, g); \
    end \
  end

module test_arith_logic_instr_exec;
  localparam int MC = 4;
  logic                core_clk, sys_rst, instr_valid;
  logic [7:0]          opcode, operand1, operand2, mem_rdata, acc, mem_addr, mem_wdata;
  logic [15:0]         pc_value, branch_target;
  logic [1:0]          reg_bank, instr_len, instr_cycles;
  logic                busy, done, illegal, mem_rd, mem_wr;
  ale_pkg::ale_flags_t flags;
  logic [7:0]          mem [256];
  logic [7:0]          m_acc;
  logic                m_cy, m_ac, m_ov;
  int                  fails, samples_checked, cyc;

  ale_exec #(.MC_CLKS(MC)) ale_exec_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
    .opcode(opcode), .operand1(operand1), .operand2(operand2),
    .pc_value(pc_value), .reg_bank(reg_bank), .mem_rdata(mem_rdata),
    .busy(busy), .done(done), .illegal(illegal), .instr_len(instr_len),
    .instr_cycles(instr_cycles), .branch_target(branch_target), .acc(acc),
    .flags(flags), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Internal data memory: one cycle read latency
  always @(posedge core_clk) begin
    if (sys_rst) mem_rdata <= 8'h00;
    else if (mem_rd === 1'b1) mem_rdata <= mem[mem_addr];
    if (mem_wr === 1'b1) mem[mem_addr] <= mem_wdata;
  end

  // Whole run needs about 1100 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 12000) begin
      fails++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Offers one instruction; with spam set, offers another while busy
  task automatic exe(input logic [7:0] op, a, b, input bit spam);
    int n;
    @(posedge core_clk);
    instr_valid <= 1'b1;
    opcode <= op;
    operand1 <= a;
    operand2 <= b;
    pc_value <= {a, op};
    @(posedge core_clk);
    instr_valid <= 1'b0;
    for (n = 0; n < 40; n++) begin
      @(negedge core_clk);
      if (done === 1'b1 || illegal === 1'b1) break;
      @(posedge core_clk);
      if (n == 0) instr_valid <= spam;
      if (n == 0) opcode <= 8'h64;
      if (n == 2) instr_valid <= 1'b0;
    end
    if (n == 40) begin
      fails++;
      $display("mismatch completion exp 1 got 0");
    end
  endtask

  task automatic step(input logic [7:0] op, a, b, input bit spam = 1'b0);
    logic [3:0] h, l;
    logic [7:0] p, x, d;
    logic [8:0] t;
    logic       ci, lg, gr;
    logic [1:0] el, ec;
    h = op[7:4];
    l = op[3:0];
    gr = h inside {4'h4, 4'h5, 4'h6};
    lg = op == 8'h33 || op == 8'h13 || (gr && l > 4'h1)
      || (h inside {4'h2, 4'h3, 4'h9} && l > 4'h3);
    d = mem[a];
    p = l == 4'h2 ? m_acc : l == 4'h3 ? b : l == 4'h4 ? a : l == 4'h5 ? d
      : l < 4'h8 ? mem[mem[{3'h0, reg_bank, 2'h0, l[0]}]] : mem[{3'h0, reg_bank, l[2:0]}];
    x = l < 4'h4 ? d : m_acc;
    x = h == 4'h4 ? x | p : h == 4'h5 ? x & p : x ^ p;
    ci = h != 4'h2 && m_cy;
    el = !lg ? 2'h0 : gr && l == 4'h3 ? 2'h3
      : l < 4'h6 && op != 8'h33 && op != 8'h13 ? 2'h2 : 2'h1;
    ec = gr && l == 4'h3 ? 2'h2 : 2'h1;
    exe(op, a, b, spam);
    `CHK("done", lg, done)
    `CHK("illegal", !lg, illegal)
    if (!lg) t = 9'h000;
    else if (op == 8'h33) {m_cy, m_acc} = {m_acc, m_cy};
    else if (op == 8'h13) {m_cy, m_acc} = {m_acc[0], m_cy, m_acc[7:1]};
    else if (h == 4'h9) begin
      t = {1'b0, m_acc} - p - ci;
      m_ac = {1'b0, m_acc[3:0]} < p[3:0] + ci;
      m_ov = (m_acc[7] ^ p[7]) & (m_acc[7] ^ t[7]);
      {m_cy, m_acc} = t;
    end else if (!gr) begin
      t = m_acc + p + ci;
      m_ac = m_acc[3:0] + p[3:0] + ci > 5'h0f;
      m_ov = ~(m_acc[7] ^ p[7]) & (m_acc[7] ^ t[7]);
      {m_cy, m_acc} = t;
    end else if (l > 4'h3) m_acc = x;
    `CHK("acc", m_acc, acc)
    `CHK("flags", {m_cy, m_ac, m_ov}, flags)
    `CHK("length", el, instr_len)
    if (lg) `CHK("cycles", ec, instr_cycles)
    if (lg) `CHK("target", {a, op} + {{8{a[7]}}, a}, branch_target)
    if (lg && gr && l < 4'h4) `CHK("direct byte", x, mem[a])
  endtask

  task automatic t_reset();
    `CHK("flags", 3'h0, flags)
    `CHK("acc", 8'h00, acc)
    `CHK("busy", 1'b0, busy)
  endtask

  // Every addressing form of every class, banks differ between calls
  task automatic t_sweep(input logic [1:0] bank);
    logic [3:0] hs [6] = '{4'h2, 4'h3, 4'h9, 4'h4, 4'h5, 4'h6};
    @(posedge core_clk);
    reg_bank <= bank;
    @(negedge core_clk);
    foreach (hs[i]) begin
      for (int l = 2; l < 16; l++) begin
        step({hs[i], 4'(l)}, 8'h71 + 8'(l * 29 + i * 7), 8'h5a ^ 8'(l));
      end
    end
  endtask

  task automatic t_rotate();
    for (int i = 0; i < 10; i++) begin
      step(i[1] ? 8'h13 : 8'h33, 8'(i * 19), 8'h00);
    end
  endtask

  // Offer while busy is ignored; opcodes outside the group are refused
  task automatic t_odd();
    logic [7:0] bad [4] = '{8'h00, 8'h74, 8'he4, 8'hff};
    step(8'h24, 8'h01, 8'h00, 1'b1);
    step(8'h94, 8'h80, 8'h00, 1'b1);
    foreach (bad[i]) begin
      step(bad[i], 8'h10, 8'h00);
    end
  endtask

  initial begin
    sys_rst = 1'b1;
    instr_valid = 1'b0;
    opcode = 8'h00;
    operand1 = 8'h00;
    operand2 = 8'h00;
    pc_value = 16'h0000;
    reg_bank = 2'h0;
    {m_acc, m_cy, m_ac, m_ov} = 11'h000;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i * 151 + 13);
    end
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk);
    t_reset();
    t_sweep(2'h1);
    t_rotate();
    t_sweep(2'h2);
    t_odd();
    close_out();
  end
endmodule
